// >>> include/dio_defs.vh
// Purpose: Constants for the drive interface option logic
// Assumes: 25 MHz core clock
// Notes:   Included by the option logic design file only
`ifndef DIO_DEFS_VH
`define DIO_DEFS_VH

// ****************************************
// Timing
// ****************************************
`define DIO_CLK_HZ           25000000
`define DIO_HEAD_SETTLE_MS   35
`define DIO_MS_PER_S         1000
`define DIO_SETTLE_CNT_W     20

// ****************************************
// Register map (word index on the bus)
// ****************************************
`define DIO_ADDR_W           4
`define DIO_DATA_W           16
`define DIO_REG_STATUS       4'h0
`define DIO_REG_CTRL         4'h1

// ****************************************
// Status fields
// ****************************************
`define DIO_ST_DISK_CHANGE   0
`define DIO_ST_HEAD_LOADED   1
`define DIO_ST_STEP_EN       2
`define DIO_ST_DOOR_LOCK     3
`define DIO_ST_SIDE          4
`define DIO_ST_WRITE_EN      5
`define DIO_ST_SETTLED       6
`define DIO_ST_SELECTED      7

// ****************************************
// Control fields and reset value
// ****************************************
`define DIO_CT_OUT_EN        0
`define DIO_CT_DC_CLEAR      1
`define DIO_CT_FORCE_UNLOCK  2
`define DIO_CTRL_RESET       16'h0001
`define DIO_DATA_ZERO        16'h0000

`endif

// >>> design/dio_door_latch.v
// Purpose: Door lock latch toggled by drive select edges
// Assumes: Inputs synchronous to i_clk
// Notes:   Latch idles unlocked after reset
`timescale 1ns/1ns
module dio_door_latch (
    input  wire i_clk,
    input  wire i_rst,
    input  wire i_enable,
    input  wire i_select,
    input  wire i_in_use,
    input  wire i_force_unlock,
    output reg  o_locked
);

// ****************************************
// Select edge detection
// ****************************************
reg select_d;
reg next_locked;

always @(posedge i_clk) begin
    if (i_rst) begin
        select_d <= 1'b0;
    end else begin
        select_d <= i_select;
    end
end

// ****************************************
// Latch
// ****************************************
always @* begin
    next_locked = o_locked;
    if (!i_enable || i_force_unlock) begin
        next_locked = 1'b0;
    end else if (i_select && !select_d) begin
        if (!o_locked) begin
            next_locked = 1'b1;
        end else if (!i_in_use) begin
            next_locked = 1'b0;
        end
    end
end

always @(posedge i_clk) begin
    if (i_rst) begin
        o_locked <= 1'b0;
    end else begin
        o_locked <= next_locked;
    end
end

endmodule

// >>> design/dio_option_logic.v
// Purpose: Strap-configured interface option logic of a diskette drive
// Assumes: One 25 MHz clock, cable inputs synchronous, straps static
// Notes:   Cable lines modelled active high; oe_n low means driving
`timescale 1ns/1ns
`include "dio_defs.vh"
module dio_option_logic #(
    parameter HEAD_SETTLE_CYCLES = `DIO_HEAD_SETTLE_MS * (`DIO_CLK_HZ / `DIO_MS_PER_S)
) (
    input  wire                     i_clk,
    input  wire                     i_rst,
    // Cable inputs
    input  wire                     i_drive_select,
    input  wire                     i_head_load_in,
    input  wire                     i_in_use_in,
    input  wire                     i_direction,
    input  wire                     i_side_select,
    input  wire                     i_step,
    input  wire                     i_write_gate,
    // Mechanism inputs
    input  wire                     i_door_closed,
    input  wire                     i_disk_present,
    input  wire                     i_ready,
    input  wire                     i_write_protected,
    input  wire                     i_two_sided_media,
    input  wire                     i_index_raw,
    input  wire                     i_sector_raw,
    // Straps
    input  wire                     i_radial_index_strap,
    input  wire                     i_index_out_strap,
    input  wire                     i_sector_out_strap,
    input  wire                     i_two_sided_strap,
    input  wire                     i_disk_change_out_strap,
    input  wire                     i_latch_reset_ready_only_pad,
    input  wire                     i_deferred_head_load_strap,
    input  wire                     i_stepper_from_select_strap,
    input  wire                     i_stepper_from_headload_strap,
    input  wire                     i_head_load_only_strap,
    input  wire                     i_in_use_alt_strap,
    input  wire                     i_door_latch_strap,
    input  wire                     i_side_via_direction_strap,
    input  wire                     i_standard_side_input_strap,
    input  wire                     i_write_allow_override_strap,
    // Register port
    input  wire [`DIO_ADDR_W-1:0]   i_addr,
    input  wire [`DIO_DATA_W-1:0]   i_wdata,
    input  wire                     i_wr,
    input  wire                     i_rd,
    output reg  [`DIO_DATA_W-1:0]   o_rdata,
    // Cable outputs
    output reg                      o_index,
    output reg                      o_index_oe_n,
    output reg                      o_sector,
    output reg                      o_sector_oe_n,
    output reg                      o_two_sided,
    output reg                      o_two_sided_oe_n,
    output reg                      o_disk_change,
    output reg                      o_disk_change_oe_n,
    output reg                      o_write_protect,
    // Mechanism outputs
    output reg                      o_head_load,
    output reg                      o_step_motor_en,
    output reg                      o_step_pulse,
    output reg                      o_door_lock,
    output reg                      o_busy_led,
    output reg                      o_side,
    output reg                      o_write_enable,
    output reg                      o_head_settled
);

// ****************************************
// Control register
// ****************************************
reg  [`DIO_DATA_W-1:0]       ctrl;
wire                         out_en       = ctrl[`DIO_CT_OUT_EN];
wire                         force_unlock = ctrl[`DIO_CT_FORCE_UNLOCK];
wire                         sw_dc_clear  = i_wr && (i_addr == `DIO_REG_CTRL) && i_wdata[`DIO_CT_DC_CLEAR];

always @(posedge i_clk) begin
    if (i_rst) begin
        ctrl <= `DIO_CTRL_RESET;
    end else if (i_wr && (i_addr == `DIO_REG_CTRL)) begin
        // Clear bit is a pulse and never stored
        ctrl <= i_wdata & ~(`DIO_CTRL_RESET << `DIO_CT_DC_CLEAR);
    end
end

// ****************************************
// Selection, head load and stepper
// ****************************************
reg  next_head_load;
reg  next_step_en;
reg  next_step_pulse;

always @* begin
    if (i_head_load_only_strap) begin
        next_head_load = i_head_load_in;
        next_step_en   = i_drive_select;
    end else if (i_stepper_from_select_strap && !i_stepper_from_headload_strap) begin
        next_head_load = i_drive_select && i_head_load_in;
        next_step_en   = i_drive_select;
    end else if (i_deferred_head_load_strap) begin
        next_head_load = i_drive_select && i_head_load_in;
        next_step_en   = i_drive_select && i_head_load_in;
    end else begin
        next_head_load = i_drive_select;
        next_step_en   = i_drive_select;
    end
    // Door and head interlock bypassed only by the select-stepper option
    if (i_stepper_from_select_strap && !i_stepper_from_headload_strap) begin
        next_step_pulse = i_step && next_step_en;
    end else begin
        next_step_pulse = i_step && next_step_en && i_door_closed && next_head_load;
    end
end

// ****************************************
// Head settle timer
// ****************************************
// Status only; the controller owns the wait, drive just reports it
// Full-width end count, cut on purpose to the counter width
localparam [31:0]                  SETTLE_LAST_FULL = HEAD_SETTLE_CYCLES - 1;
localparam [`DIO_SETTLE_CNT_W-1:0] SETTLE_LAST      = SETTLE_LAST_FULL[`DIO_SETTLE_CNT_W-1:0];
reg  [`DIO_SETTLE_CNT_W-1:0] settle_cnt;
reg                          settled;

always @(posedge i_clk) begin
    if (i_rst || !next_head_load) begin
        settle_cnt <= {`DIO_SETTLE_CNT_W{1'b0}};
        settled    <= 1'b0;
    end else if (!settled) begin
        if (settle_cnt == SETTLE_LAST) begin
            settled <= 1'b1;
        end else begin
            settle_cnt <= settle_cnt + 1'b1;
        end
    end
end

// ****************************************
// Side selection
// ****************************************
reg  next_side;

always @* begin
    if (i_side_via_direction_strap && !i_standard_side_input_strap) begin
        // Direction keeps its step role; only a loaded head takes it as side
        next_side = next_head_load ? i_direction : o_side;
    end else if (i_standard_side_input_strap) begin
        next_side = i_side_select;
    end else begin
        next_side = 1'b0;
    end
end

// ****************************************
// Disk change latch
// ****************************************
reg  dc_latch;
wire side_ok  = i_drive_select && (!next_side || i_two_sided_media);
wire dc_set   = !i_disk_present || !i_door_closed;
wire dc_clear = sw_dc_clear || (i_ready && (i_latch_reset_ready_only_pad || side_ok));

always @(posedge i_clk) begin
    if (i_rst) begin
        dc_latch <= 1'b0;
    end else if (dc_set) begin
        dc_latch <= 1'b1;
    end else if (dc_clear) begin
        dc_latch <= 1'b0;
    end
end

// ****************************************
// Door lock and busy indicator
// ****************************************
wire door_latched;
wire in_use_alt = i_in_use_alt_strap && i_in_use_in;

dio_door_latch u_door_latch (
    .i_clk          (i_clk),
    .i_rst          (i_rst),
    .i_enable       (i_door_latch_strap && i_in_use_alt_strap),
    .i_select       (i_drive_select),
    .i_in_use       (i_in_use_in),
    .i_force_unlock (force_unlock),
    .o_locked       (door_latched)
);

wire next_door = !force_unlock && (door_latched || in_use_alt);
wire next_busy = i_in_use_alt_strap ? i_in_use_in : i_drive_select;

// ****************************************
// Write inhibit
// ****************************************
wire wp_block  = i_write_protected && !i_write_allow_override_strap;
wire next_wren = i_write_gate && next_head_load && i_drive_select && !wp_block;

// ****************************************
// Output gating
// ****************************************
// Enabled radial lines drive without select; bussed lines only when selected
wire idx_drive = out_en && i_index_out_strap && (i_radial_index_strap || i_drive_select);
wire sec_drive = out_en && i_sector_out_strap && (i_radial_index_strap || i_drive_select);
wire ts_drive  = out_en && i_two_sided_strap && i_drive_select;
wire dc_drive  = out_en && i_disk_change_out_strap && i_drive_select;

always @(posedge i_clk) begin
    if (i_rst) begin
        o_index            <= 1'b0;
        o_index_oe_n       <= 1'b1;
        o_sector           <= 1'b0;
        o_sector_oe_n      <= 1'b1;
        o_two_sided        <= 1'b0;
        o_two_sided_oe_n   <= 1'b1;
        o_disk_change      <= 1'b0;
        o_disk_change_oe_n <= 1'b1;
        o_write_protect    <= 1'b0;
        o_head_load        <= 1'b0;
        o_step_motor_en    <= 1'b0;
        o_step_pulse       <= 1'b0;
        o_door_lock        <= 1'b0;
        o_busy_led         <= 1'b0;
        o_side             <= 1'b0;
        o_write_enable     <= 1'b0;
        o_head_settled     <= 1'b0;
    end else begin
        o_index            <= idx_drive && i_index_raw;
        o_index_oe_n       <= !idx_drive;
        o_sector           <= sec_drive && i_sector_raw;
        o_sector_oe_n      <= !sec_drive;
        o_two_sided        <= ts_drive && i_two_sided_media;
        o_two_sided_oe_n   <= !ts_drive;
        o_disk_change      <= dc_drive && dc_latch;
        o_disk_change_oe_n <= !dc_drive;
        o_write_protect    <= out_en && i_drive_select && i_write_protected;
        o_head_load        <= next_head_load;
        o_step_motor_en    <= next_step_en;
        o_step_pulse       <= next_step_pulse;
        o_door_lock        <= next_door;
        o_busy_led         <= next_busy;
        o_side             <= next_side;
        o_write_enable     <= next_wren;
        o_head_settled     <= settled;
    end
end

// ****************************************
// Register read port
// ****************************************
reg  [`DIO_DATA_W-1:0] status;

always @* begin
    status = `DIO_DATA_ZERO;
    status[`DIO_ST_DISK_CHANGE] = dc_latch;
    status[`DIO_ST_HEAD_LOADED] = o_head_load;
    status[`DIO_ST_STEP_EN]     = o_step_motor_en;
    status[`DIO_ST_DOOR_LOCK]   = o_door_lock;
    status[`DIO_ST_SIDE]        = o_side;
    status[`DIO_ST_WRITE_EN]    = o_write_enable;
    status[`DIO_ST_SETTLED]     = settled;
    status[`DIO_ST_SELECTED]    = i_drive_select;
end

always @(posedge i_clk) begin
    if (i_rst) begin
        o_rdata <= `DIO_DATA_ZERO;
    end else if (i_rd) begin
        if (i_addr == `DIO_REG_STATUS) begin
            o_rdata <= status;
        end else if (i_addr == `DIO_REG_CTRL) begin
            o_rdata <= ctrl;
        end else begin
            o_rdata <= `DIO_DATA_ZERO;
        end
    end else begin
        // Data stands only in the cycle after the read
        o_rdata <= `DIO_DATA_ZERO;
    end
end

endmodule

// >>> verif/dio_host_model.sv
// Purpose: Host controller model on the drive cable
// Assumes: Bench asks for levels, model applies host ordering
// Notes:   Remaining cable lines are driven by the bench itself
`timescale 1ns/1ns
module dio_host_model (
    input  wire  i_clk,
    input  wire  i_rst,
    input  wire  i_load_first,
    input  wire  i_want_sel,
    input  wire  i_want_hl,
    input  wire  i_want_wr,
    input  wire  i_head_settled,
    output logic o_sel = 1'h0,
    output logic o_hl = 1'h0,
    output logic o_wg = 1'h0
);
    // ****************************************
    // Cable drive
    // ****************************************
    always @(posedge i_clk) begin
        o_hl <= i_want_hl & !i_rst;
        // With i_load_first set, select held back until own head is loaded
        o_sel <= i_want_sel & !i_rst & (!i_load_first | o_hl);
        // Write gate waits for head settle, else data is garbage
        o_wg <= i_want_wr & !i_rst & i_head_settled;
    end
endmodule

// >>> verif/dio_option_logic_asserts.sv
// Purpose: Port checks of the option logic
// Assumes: Straps steady around each checked edge
// Notes:   Outputs registered one cycle after cause
`timescale 1ns/1ns
module dio_option_asserts #(
    parameter HEAD_SETTLE_CYCLES = 8
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_drive_select,
    input wire i_head_load_in,
    input wire i_in_use_in,
    input wire i_door_closed,
    input wire i_write_protected,
    input wire i_two_sided_strap,
    input wire i_disk_change_out_strap,
    input wire i_deferred_head_load_strap,
    input wire i_stepper_from_select_strap,
    input wire i_stepper_from_headload_strap,
    input wire i_head_load_only_strap,
    input wire i_in_use_alt_strap,
    input wire i_write_allow_override_strap,
    input wire o_two_sided_oe_n,
    input wire o_disk_change_oe_n,
    input wire o_head_load,
    input wire o_step_motor_en,
    input wire o_step_pulse,
    input wire o_busy_led,
    input wire o_write_enable
);
    wire gated = !i_head_load_only_strap & !(i_stepper_from_select_strap & !i_stepper_from_headload_strap);
    wire dflt  = gated & !i_deferred_head_load_strap;
    wire defer = gated & i_deferred_head_load_strap;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ****************************************
    // Properties
    // ****************************************
    property p_sel_loads; dflt & i_drive_select |=> o_head_load & o_step_motor_en; endproperty
    a_sel_loads: assert property (p_sel_loads) else $error("select did not load head");
    property p_defer; (defer & !i_head_load_in) [*2] |-> !o_head_load; endproperty
    a_defer: assert property (p_defer) else $error("head loaded without head load input");
    property p_hl_only; i_head_load_only_strap & i_head_load_in & !i_drive_select |=> o_head_load & !o_step_motor_en; endproperty
    a_hl_only: assert property (p_hl_only) else $error("head load only mode wrong");
    property p_ts_off; !i_two_sided_strap |=> o_two_sided_oe_n; endproperty
    a_ts_off: assert property (p_ts_off) else $error("two sided driven while disabled");
    property p_dc_off; !i_disk_change_out_strap |=> o_disk_change_oe_n; endproperty
    a_dc_off: assert property (p_dc_off) else $error("disk change driven while disabled");
    property p_wr_block; i_write_protected & !i_write_allow_override_strap |=> !o_write_enable; endproperty
    a_wr_block: assert property (p_wr_block) else $error("write on protected disk");
    property p_busy; i_in_use_alt_strap & i_in_use_in |=> o_busy_led; endproperty
    a_busy: assert property (p_busy) else $error("busy lamp off while in use");
    property p_no_step; gated & !i_door_closed |=> !o_step_pulse; endproperty
    a_no_step: assert property (p_no_step) else $error("step with door open");
    c_sel: cover property (dflt & i_drive_select ##1 o_head_load);
    c_busy: cover property (i_in_use_alt_strap & i_in_use_in ##1 o_busy_led);
    c_write: cover property (o_write_enable);
endmodule
bind dio_option_logic dio_option_asserts #(.HEAD_SETTLE_CYCLES(HEAD_SETTLE_CYCLES)) u_chk (.*);

// >>> verif/dio_option_logic_tb_top.sv
// Purpose: Self-checking bench for the option logic
// Assumes: Settle count shortened to 8 cycles
// Notes:   Straps also changed within tests, a few cycles before each check
`timescale 1ns/1ns
module dio_option_logic_tb_top;
    logic i_clk = 1'h0, i_rst = 1'h1, i_wr = 1'h0, i_rd = 1'h0;
    logic i_in_use_in = 1'h0, i_direction = 1'h0, i_side_select = 1'h0, i_step = 1'h0;
    logic i_door_closed = 1'h1, i_disk_present = 1'h1, i_ready = 1'h0, i_write_protected = 1'h0;
    logic i_two_sided_media = 1'h0, i_index_raw = 1'h0, i_sector_raw = 1'h0;
    logic i_radial_index_strap = 1'h0, i_index_out_strap = 1'h1, i_sector_out_strap = 1'h1;
    logic i_two_sided_strap = 1'h0, i_disk_change_out_strap = 1'h0, i_latch_reset_ready_only_pad = 1'h0;
    logic i_deferred_head_load_strap = 1'h0, i_stepper_from_select_strap = 1'h0, i_head_load_only_strap = 1'h0;
    logic i_stepper_from_headload_strap = 1'h1, i_in_use_alt_strap = 1'h0, i_door_latch_strap = 1'h0;
    logic i_side_via_direction_strap = 1'h0, i_standard_side_input_strap = 1'h1;
    logic i_write_allow_override_strap = 1'h0, want_sel = 1'h0, want_hl = 1'h0, want_wr = 1'h0;
    logic [3:0]  i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000, o_rdata;
    logic o_index, o_index_oe_n, o_sector, o_sector_oe_n, o_two_sided, o_two_sided_oe_n, o_disk_change;
    logic o_disk_change_oe_n, o_write_protect, o_head_load, o_step_motor_en, o_step_pulse, o_door_lock;
    logic o_busy_led, o_side, o_write_enable, o_head_settled;
    wire  i_drive_select, i_head_load_in, i_write_gate;
    int   err_total = 0, check_count = 0, cyc = 0;
    dio_option_logic #(.HEAD_SETTLE_CYCLES(8)) uut (.*);
    dio_host_model host (.i_clk, .i_rst, .i_load_first(i_head_load_only_strap), .i_want_sel(want_sel),
        .i_want_hl(want_hl), .i_want_wr(want_wr), .i_head_settled(o_head_settled), .o_sel(i_drive_select),
        .o_hl(i_head_load_in), .o_wg(i_write_gate));
    always #20 i_clk = ~i_clk;
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (e !== g) begin
            err_total++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk); i_wr <= 1'h1; i_addr <= a; i_wdata <= d;
        @(posedge i_clk); i_wr <= 1'h0;
    endtask
    task automatic rd(input string nm, input logic [3:0] a, input logic [15:0] e);
        @(posedge i_clk); i_rd <= 1'h1; i_addr <= a;
        @(posedge i_clk); i_rd <= 1'h0;
        #1 chk(nm, e, o_rdata);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Hang guard, run needs well under 1000 cycles
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            finish_test;
        end
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        tick(7); @(posedge i_clk); i_rst <= 1'h0; tick(2);
        rd("ctrl", 4'h1, 16'h0001); rd("unmapped", 4'h7, 16'h0000); rd("status", 4'h0, 16'h0000);
        chk("idx_oe_n", 1'h1, o_index_oe_n);
        $display("test reset done");
        @(posedge i_clk); want_sel <= 1'h1; tick(14);
        chk("head", 1'h1, o_head_load); chk("step_en", 1'h1, o_step_motor_en);
        chk("settled", 1'h1, o_head_settled);
        chk("idx_oe_n", 1'h0, o_index_oe_n); chk("sec_oe_n", 1'h0, o_sector_oe_n);
        chk("ts_oe_n", 1'h1, o_two_sided_oe_n); chk("dc_oe_n", 1'h1, o_disk_change_oe_n);
        rd("status", 4'h0, 16'h00c6);
        wr(4'h1, 16'h0000); rd("ctrl", 4'h1, 16'h0000); wr(4'h1, 16'h0001);
        @(posedge i_clk); i_two_sided_strap <= 1'h1; i_disk_change_out_strap <= 1'h1; i_index_out_strap <= 1'h0;
        tick(3); chk("ts_oe_n", 1'h0, o_two_sided_oe_n); chk("dc_oe_n", 1'h0, o_disk_change_oe_n);
        chk("idx_oe_n", 1'h1, o_index_oe_n);
        $display("test select done");
        @(posedge i_clk); i_index_out_strap <= 1'h1; i_ready <= 1'h1; i_side_select <= 1'h1; i_door_closed <= 1'h0;
        tick(3); chk("dc", 1'h1, o_disk_change);
        @(posedge i_clk); i_door_closed <= 1'h1; tick(3); chk("dc", 1'h1, o_disk_change);
        wr(4'h1, 16'h0003); rd("ctrl", 4'h1, 16'h0001); chk("dc", 1'h0, o_disk_change);
        @(posedge i_clk); i_door_closed <= 1'h0; tick(2); chk("dc", 1'h1, o_disk_change);
        @(posedge i_clk); i_door_closed <= 1'h1; tick(3); chk("dc", 1'h1, o_disk_change);
        @(posedge i_clk); i_side_select <= 1'h0; tick(3); chk("dc", 1'h0, o_disk_change);
        @(posedge i_clk); i_latch_reset_ready_only_pad <= 1'h1; i_side_select <= 1'h1; i_disk_present <= 1'h0;
        tick(3); chk("dc", 1'h1, o_disk_change);
        @(posedge i_clk); i_disk_present <= 1'h1; tick(3); chk("dc", 1'h0, o_disk_change);
        $display("test disk change done");
        @(posedge i_clk); i_side_select <= 1'h0; i_door_closed <= 1'h0; i_step <= 1'h1; i_two_sided_media <= 1'h1;
        tick(3); chk("step", 1'h0, o_step_pulse); chk("ts", 1'h1, o_two_sided);
        @(posedge i_clk); i_door_closed <= 1'h1; tick(3); chk("step", 1'h1, o_step_pulse);
        @(posedge i_clk); i_stepper_from_select_strap <= 1'h1; i_stepper_from_headload_strap <= 1'h0;
        i_door_closed <= 1'h0; tick(3);
        chk("step", 1'h1, o_step_pulse); chk("head", 1'h0, o_head_load);
        @(posedge i_clk); i_stepper_from_select_strap <= 1'h0; i_stepper_from_headload_strap <= 1'h1;
        i_door_closed <= 1'h1; i_step <= 1'h0; i_deferred_head_load_strap <= 1'h1;
        tick(3); chk("head", 1'h0, o_head_load);
        @(posedge i_clk); want_hl <= 1'h1; tick(3);
        chk("head", 1'h1, o_head_load); chk("step_en", 1'h1, o_step_motor_en);
        @(posedge i_clk); i_deferred_head_load_strap <= 1'h0; i_head_load_only_strap <= 1'h1; want_sel <= 1'h0;
        tick(3); chk("head", 1'h1, o_head_load); chk("step_en", 1'h0, o_step_motor_en);
        $display("test head modes done");
        @(posedge i_clk); i_head_load_only_strap <= 1'h0; want_hl <= 1'h0; i_in_use_alt_strap <= 1'h1;
        i_in_use_in <= 1'h1; tick(3);
        chk("busy", 1'h1, o_busy_led); chk("lock", 1'h1, o_door_lock);
        wr(4'h1, 16'h0005); tick(2); chk("lock", 1'h0, o_door_lock); wr(4'h1, 16'h0001);
        @(posedge i_clk); i_in_use_in <= 1'h0; i_door_latch_strap <= 1'h1; tick(3);
        @(posedge i_clk); want_sel <= 1'h1; tick(3);
        @(posedge i_clk); want_sel <= 1'h0; tick(3); chk("lock", 1'h1, o_door_lock);
        @(posedge i_clk); want_sel <= 1'h1; tick(3); chk("lock", 1'h0, o_door_lock);
        $display("test door done");
        @(posedge i_clk); i_door_latch_strap <= 1'h0; i_in_use_alt_strap <= 1'h0; i_write_protected <= 1'h1;
        want_wr <= 1'h1; tick(14);
        chk("wr_en", 1'h0, o_write_enable); chk("wp", 1'h1, o_write_protect);
        @(posedge i_clk); i_write_allow_override_strap <= 1'h1; tick(3);
        chk("wr_en", 1'h1, o_write_enable); chk("wp", 1'h1, o_write_protect);
        @(posedge i_clk); i_side_via_direction_strap <= 1'h1; i_standard_side_input_strap <= 1'h0;
        i_direction <= 1'h1; tick(3); chk("side", 1'h1, o_side);
        @(posedge i_clk); i_direction <= 1'h0; tick(3); chk("side", 1'h0, o_side);
        $display("test write and side done");
        @(posedge i_clk); i_radial_index_strap <= 1'h1; want_sel <= 1'h0; i_index_raw <= 1'h1;
        i_sector_raw <= 1'h1; tick(3);
        chk("idx", 1'h1, o_index); chk("idx_oe_n", 1'h0, o_index_oe_n);
        chk("sec", 1'h1, o_sector); chk("sec_oe_n", 1'h0, o_sector_oe_n);
        $display("test radial done");
        finish_test;
    end
endmodule
